// ==== hdl/ahb_device.sv ====
// module: device end of the parallel host port, cycle control and ready/wait
`timescale 1ns/1ps
module ahb_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host bus
  ahb_bus_if.device bus,
  // buffer state from the scan side
  input wire logic tdo_room,
  input wire logic tms0_full,
  input wire logic tms1_full,
  input wire logic tdi_has_byte,
  input wire logic [7:0] tdi_byte,
  input wire logic [7:0] other_rd_byte,
  // written bytes to the scan side
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [2:0] wr_target,
  output logic [7:0] wr_byte,
  // read completion and status refresh
  output logic rd_done,
  output logic [2:0] rd_target,
  output logic status_refresh
);
  // ==========================================================
  // input synchronisers
  logic [1:0] ce_s, stb_s, rw_s;
  logic [2:0] sel_m, sel_s;
  logic [7:0] dat_m, dat_s;
  logic act_prev_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ce_s <= 2'h3;
      stb_s <= 2'h3;
      rw_s <= 2'h0;
      sel_m <= 3'h0;
      sel_s <= 3'h0;
      dat_m <= 8'h00;
      dat_s <= 8'h00;
      act_prev_q <= 1'b0;
    end else begin
      ce_s <= {ce_s[0], bus.chip_en_n};
      stb_s <= {stb_s[0], bus.bus_strobe_n};
      rw_s <= {rw_s[0], bus.rd_wr_sel};
      sel_m <= bus.reg_select;
      sel_s <= sel_m;
      dat_m <= bus.host_byte_o;
      dat_s <= dat_m;
      act_prev_q <= !ce_s[1] && !stb_s[1];
    end
  end
  // ==========================================================
  // cycle decode
  logic active, strobe_rise;
  // enable and strobe are one gate, so their order never matters
  assign active = !ce_s[1] && !stb_s[1];
  // the cycle ends when the gate closes, so the host may lift both pins at once
  assign strobe_rise = act_prev_q && !active;
  // ==========================================================
  // write fifo toward the scan side
  logic f_in_valid, f_in_ready;
  logic [10:0] f_out;
  ahb_fifo #(.WIDTH(11), .DEPTH(ahb_pkg::FIFO_DEPTH)) u_wfifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({sel_s, dat_s}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(f_out)
  );
  assign wr_target = f_out[10:8];
  assign wr_byte = f_out[7:0];
  // ==========================================================
  // separate write and read engines
  ahb_pkg::ahb_dev_state_t ws_q, ws_d, rs_q, rs_d;
  logic wr_ok, rd_ok, wr_go, rd_go;
  logic rdy_q, rdy_d, oe_q, oe_d, done_q, done_d, upd_q, upd_d;
  logic [7:0] dout_q, dout_d;
  logic [2:0] rtgt_q, rtgt_d;
  logic ref_fall_q, ref_fall_d;
  always_comb begin
    // full means fifo or addressed buffer cannot take a byte
    wr_ok = f_in_ready;
    case (sel_s)
      ahb_pkg::SEL_TDO: wr_ok = f_in_ready && tdo_room;
      ahb_pkg::SEL_TMS0: wr_ok = f_in_ready && !tms0_full;
      ahb_pkg::SEL_TMS1: wr_ok = f_in_ready && !tms1_full;
      default: wr_ok = f_in_ready;
    endcase
    rd_ok = (sel_s != ahb_pkg::SEL_TDI) || tdi_has_byte;
    wr_go = active && !rw_s[1];
    rd_go = active && rw_s[1];
  end
  // ==========================================================
  // half-rate phase
  // completion steps on alternate edges, modelling the falling clock phase
  always_comb begin
    ref_fall_d = !ref_fall_q;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ref_fall_q <= 1'b0;
    end else begin
      ref_fall_q <= ref_fall_d;
    end
  end
  // ==========================================================
  // write engine
  always_comb begin
    ws_d = ws_q;
    upd_d = 1'b0;
    f_in_valid = 1'b0;
    // status control writes act at once and are never queued
    case (ws_q)
      ahb_pkg::DS_IDLE: if (wr_go && wr_ok) ws_d = ahb_pkg::DS_WAIT;
      ahb_pkg::DS_WAIT: begin
        if (strobe_rise) begin
          f_in_valid = (sel_s != ahb_pkg::SEL_STATUS_CTRL);
          upd_d = (sel_s == ahb_pkg::SEL_STATUS_CTRL) && dat_s[ahb_pkg::UPD_STATUS_BIT];
          ws_d = ahb_pkg::DS_DONE;
        end
      end
      ahb_pkg::DS_DONE: if (ref_fall_q) ws_d = ahb_pkg::DS_RECOVER;
      ahb_pkg::DS_RECOVER: ws_d = ahb_pkg::DS_IDLE;
      default: ws_d = ahb_pkg::DS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ws_q <= ahb_pkg::DS_IDLE;
      upd_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      upd_q <= upd_d;
    end
  end
  // ==========================================================
  // read engine
  always_comb begin
    rs_d = rs_q;
    dout_d = dout_q;
    rtgt_d = rtgt_q;
    done_d = 1'b0;
    case (rs_q)
      ahb_pkg::DS_IDLE: begin
        if (rd_go && rd_ok) begin
          rs_d = ahb_pkg::DS_WAIT;
          rtgt_d = sel_s;
          dout_d = (sel_s == ahb_pkg::SEL_TDI) ? tdi_byte : other_rd_byte;
        end
      end
      ahb_pkg::DS_WAIT: begin
        if (strobe_rise) begin
          done_d = 1'b1;
          rs_d = ahb_pkg::DS_DONE;
        end
      end
      ahb_pkg::DS_DONE: if (ref_fall_q) rs_d = ahb_pkg::DS_RECOVER;
      ahb_pkg::DS_RECOVER: rs_d = ahb_pkg::DS_IDLE;
      default: rs_d = ahb_pkg::DS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rs_q <= ahb_pkg::DS_IDLE;
      dout_q <= 8'h00;
      rtgt_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      dout_q <= dout_d;
      rtgt_q <= rtgt_d;
      done_q <= done_d;
    end
  end
  // ==========================================================
  // ready and read drive
  always_comb begin
    rdy_d = 1'b1;
    oe_d = 1'b0;
    // each direction drives ready from its own engine only
    // an empty input buffer holds the host without limit; polling avoids it
    if (ws_d == ahb_pkg::DS_WAIT && wr_go) rdy_d = 1'b0;
    if (rs_d == ahb_pkg::DS_WAIT && rd_go) begin
      rdy_d = 1'b0;
      oe_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdy_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      rdy_q <= rdy_d;
      oe_q <= oe_d;
    end
  end
  assign bus.ready_wait = rdy_q;
  assign bus.dev_byte_oe = oe_q;
  assign bus.dev_byte_o = dout_q;
  assign rd_done = done_q;
  assign rd_target = rtgt_q;
  assign status_refresh = upd_q;
endmodule

// ==== hdl/ahb_pkg.sv ====
// package: constants and types for the parallel host port handshake
// How it works
// - host write: enable, select low, strobe, address
// - enable and strobe gated together internally
// - write ready low when target accepts data
// - strobe rise captures byte, ready returns high
// - host read: enable, select high, strobe, address
// - read data and ready only when available
// - strobe rise completes read, resets read logic
// - read hold-off only for input buffer
// - output buffer holds two bytes, third waits
// - completion on falling clock edge after rise
// - without ready, wait 2.5 cycles same direction
// - separate read and write paths overlap
// - missed margin: one cycle after direction pair
// - host polls readiness before buffer access
// - host sets update-status before polling status
// - address and direction select the target
// - ready table: synchroniser busy or buffer state
// - update-status write gives one refresh pulse
package ahb_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned OUT_BUF_DEPTH = 2;
  // register selects
  localparam logic [2:0] SEL_TDO = 3'h0;
  localparam logic [2:0] SEL_TDI = 3'h1;
  localparam logic [2:0] SEL_TMS0 = 3'h2;
  localparam logic [2:0] SEL_TMS1 = 3'h3;
  localparam logic [2:0] SEL_CNT = 3'h4;
  localparam logic [2:0] SEL_MODE0 = 3'h5;
  localparam logic [2:0] SEL_MODE1 = 3'h6;
  localparam logic [2:0] SEL_STATUS_CTRL = 3'h7;
  localparam int unsigned UPD_STATUS_BIT = 2;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_CTRL_RESET = 8'hb8;
  // ref_clk period and host spacing without the handshake
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned HOST_GAP_HALF_CYCLES = 5;
  localparam int unsigned HOST_GAP_CYCLES = (HOST_GAP_HALF_CYCLES + 1) / 2;
  typedef enum logic [1:0] {DS_IDLE, DS_WAIT, DS_DONE, DS_RECOVER} ahb_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_WAIT, HS_RELEASE, HS_GAP}
    ahb_host_state_t;
endpackage

// ==== hdl/ahb_bus_if.sv ====
// interface: asynchronous parallel host bus between host and device
`timescale 1ns/1ps
interface ahb_bus_if;
  logic chip_en_n;
  logic rd_wr_sel;
  logic bus_strobe_n;
  logic [2:0] reg_select;
  logic [7:0] host_byte_o;
  logic host_byte_oe;
  logic [7:0] dev_byte_o;
  logic dev_byte_oe;
  logic ready_wait;
  modport host (
    output chip_en_n, rd_wr_sel, bus_strobe_n, reg_select, host_byte_o, host_byte_oe,
    input dev_byte_o, dev_byte_oe, ready_wait
  );
  modport device (
    input chip_en_n, rd_wr_sel, bus_strobe_n, reg_select, host_byte_o, host_byte_oe,
    output dev_byte_o, dev_byte_oe, ready_wait
  );
endinterface

// ==== hdl/ahb_fifo.sv ====
// module: small valid/ready fifo
`timescale 1ns/1ps
module ahb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
endmodule

// ==== hdl/ahb_host.sv ====
// module: host end of the parallel host port
`timescale 1ns/1ps
module ahb_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host bus
  ahb_bus_if.host bus,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [2:0] req_sel,
  input wire logic [7:0] req_byte,
  // user answer
  output logic rsp_valid,
  output logic [7:0] rsp_byte
);
  ahb_pkg::ahb_host_state_t st_q, st_d;
  logic ce_q, ce_d, rw_q, rw_d, stb_q, stb_d, oe_q, oe_d, rv_q, rv_d;
  logic [2:0] sel_q, sel_d;
  logic [7:0] dat_q, dat_d, rb_q, rb_d;
  logic [1:0] gap_q, gap_d;
  logic idle_q, idle_d;
  always_comb begin
    st_d = st_q;
    ce_d = ce_q;
    rw_d = rw_q;
    stb_d = stb_q;
    oe_d = oe_q;
    sel_d = sel_q;
    dat_d = dat_q;
    rb_d = rb_q;
    rv_d = 1'b0;
    gap_d = gap_q;
    case (st_q)
      ahb_pkg::HS_IDLE: begin
        if (req_valid) begin
          ce_d = 1'b0;
          rw_d = req_read;
          sel_d = req_sel;
          dat_d = req_byte;
          oe_d = !req_read;
          st_d = ahb_pkg::HS_SETUP;
        end
      end
      ahb_pkg::HS_SETUP: begin
        stb_d = 1'b0;
        st_d = ahb_pkg::HS_WAIT;
      end
      ahb_pkg::HS_WAIT: begin
        if (!bus.ready_wait) begin
          rb_d = bus.dev_byte_o;
          rv_d = rw_q;
          stb_d = 1'b1;
          st_d = ahb_pkg::HS_RELEASE;
        end
      end
      ahb_pkg::HS_RELEASE: begin
        ce_d = 1'b1;
        oe_d = 1'b0;
        gap_d = 2'(ahb_pkg::HOST_GAP_CYCLES);
        st_d = ahb_pkg::HS_GAP;
      end
      // spacing also covers a missed margin on direction changes
      ahb_pkg::HS_GAP: begin
        if (gap_q == 2'h0) st_d = ahb_pkg::HS_IDLE;
        else gap_d = gap_q - 2'h1;
      end
      default: st_d = ahb_pkg::HS_IDLE;
    endcase
    idle_d = (st_d == ahb_pkg::HS_IDLE);
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= ahb_pkg::HS_IDLE;
      ce_q <= 1'b1;
      rw_q <= 1'b1;
      stb_q <= 1'b1;
      oe_q <= 1'b0;
      sel_q <= 3'h0;
      dat_q <= 8'h00;
      rb_q <= 8'h00;
      rv_q <= 1'b0;
      gap_q <= 2'h0;
      idle_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ce_q <= ce_d;
      rw_q <= rw_d;
      stb_q <= stb_d;
      oe_q <= oe_d;
      sel_q <= sel_d;
      dat_q <= dat_d;
      rb_q <= rb_d;
      rv_q <= rv_d;
      gap_q <= gap_d;
      idle_q <= idle_d;
    end
  end
  assign req_ready = idle_q;
  assign bus.chip_en_n = ce_q;
  assign bus.rd_wr_sel = rw_q;
  assign bus.bus_strobe_n = stb_q;
  assign bus.reg_select = sel_q;
  assign bus.host_byte_o = dat_q;
  assign bus.host_byte_oe = oe_q;
  assign rsp_valid = rv_q;
  assign rsp_byte = rb_q;
endmodule

// ==== test/ahb_bus_sva.sv ====
// checker: handshake properties on the host bus wires
`timescale 1ns/1ps
module ahb_bus_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus wires
  input wire logic chip_en_n,
  input wire logic rd_wr_sel,
  input wire logic bus_strobe_n,
  input wire logic [2:0] reg_select,
  input wire logic [7:0] host_byte_o,
  input wire logic host_byte_oe,
  input wire logic [7:0] dev_byte_o,
  input wire logic dev_byte_oe,
  input wire logic ready_wait
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // sequences
  sequence s_open;
    !chip_en_n && !bus_strobe_n;
  endsequence
  sequence s_idle;
    (chip_en_n && bus_strobe_n) [*5];
  endsequence
  // ==========================================
  // properties
  AST_RDY_CAUSE: assert property ($fell(ready_wait) |->
    !$past(chip_en_n, 3) && !$past(bus_strobe_n, 3))
    else $error("ready fell without an open cycle");
  AST_RDY_LATE: assert property ($fell(bus_strobe_n) && ready_wait |-> ready_wait [*3])
    else $error("ready fell before the synchronisers");
  AST_RDY_RELEASE: assert property ($rose(bus_strobe_n) |-> ##[1:5] ready_wait)
    else $error("ready not released after strobe rise");
  AST_STB_AFTER_RDY: assert property ($rose(bus_strobe_n) |-> !$past(ready_wait))
    else $error("strobe rose before ready");
  AST_HOST_HOLD: assert property (s_open ##0 ready_wait |-> ##1 !bus_strobe_n)
    else $error("strobe released while held off");
  AST_HOST_ORDER: assert property ($fell(bus_strobe_n) |-> !chip_en_n)
    else $error("strobe low without chip enable");
  AST_RD_DRIVE: assert property ($fell(ready_wait) && rd_wr_sel |-> dev_byte_oe)
    else $error("read ready without data driven");
  AST_RD_STABLE: assert property (dev_byte_oe && !ready_wait && $past(dev_byte_oe) |->
    $stable(dev_byte_o))
    else $error("read data moved while ready");
  AST_IDLE_HIGH: assert property (s_idle |-> ready_wait)
    else $error("ready low with no cycle");
  AST_HOST_DRIVE: assert property (s_open |-> host_byte_oe == !rd_wr_sel)
    else $error("host data drive does not match the direction");
  AST_WR_HOLD: assert property (s_open ##0 !rd_wr_sel |->
    $stable(host_byte_o) && $stable(reg_select))
    else $error("write address or data moved during the cycle");
endmodule

// ==== test/async_host_bus_handshake_tb_top.sv ====
// testbench: host and device ends joined, checked against a queue model
`timescale 1ns/1ps
module async_host_bus_handshake_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic tdo_room = 1'b1, tms0_full = 1'b0, tms1_full = 1'b0, tdi_has_byte = 1'b1;
  logic wr_ready = 1'b1, req_valid = 1'b0, req_read = 1'b0;
  logic [7:0] tdi_byte = 8'h00, other_rd_byte = 8'h00, req_byte = 8'h00;
  logic [2:0] req_sel = 3'h0;
  logic wr_valid, rd_done, status_refresh, req_ready, rsp_valid;
  logic [2:0] wr_target, rd_target;
  logic [7:0] wr_byte, rsp_byte;
  int bad_count = 0, checks = 0, seed = 32'h5e29037f;
  int n_ref = 0, n_rd = 0, x_ref = 0, x_rd = 0;
  logic [10:0] wq[$];
  logic [7:0] rq[$];
  logic [2:0] tq[$];
  ahb_bus_if bus ();
  ahb_host ahb_host_i (.ref_clk, .reset, .bus, .req_valid, .req_ready, .req_read,
    .req_sel, .req_byte, .rsp_valid, .rsp_byte);
  ahb_device ahb_device_i (.ref_clk, .reset, .bus, .tdo_room, .tms0_full, .tms1_full,
    .tdi_has_byte, .tdi_byte, .other_rd_byte, .wr_valid, .wr_ready, .wr_target,
    .wr_byte, .rd_done, .rd_target, .status_refresh);
  ahb_bus_sva ahb_bus_sva_i (.ref_clk, .reset, .chip_en_n(bus.chip_en_n),
    .rd_wr_sel(bus.rd_wr_sel), .bus_strobe_n(bus.bus_strobe_n),
    .reg_select(bus.reg_select), .host_byte_o(bus.host_byte_o),
    .host_byte_oe(bus.host_byte_oe), .dev_byte_o(bus.dev_byte_o),
    .dev_byte_oe(bus.dev_byte_oe), .ready_wait(bus.ready_wait));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cut();
    bad_count++;
    $display("ERROR wait expected done seen timeout");
    end_sim();
  endtask
  // the model entry is made as the request is driven, before the request values have landed
  task automatic send(input logic rd, input logic [2:0] sel, input logic [7:0] b);
    int i;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_sel <= sel;
    req_byte <= b;
    if (rd) begin
      rq.push_back((sel == ahb_pkg::SEL_TDI) ? tdi_byte : other_rd_byte);
      tq.push_back(sel);
      x_rd++;
    end else if (sel == ahb_pkg::SEL_STATUS_CTRL) begin
      x_ref += b[ahb_pkg::UPD_STATUS_BIT];
    end else begin
      wq.push_back({sel, b});
    end
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 3000);
    if (i >= 3000) cut();
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  // ==========================================
  // result monitor
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk("write", {wr_target, wr_byte}, (wq.size() > 0) ? wq.pop_front() : 11'h7ff);
    end
    if (rsp_valid === 1'b1) begin
      chk("read", {3'h0, rsp_byte}, (rq.size() > 0) ? {3'h0, rq.pop_front()} : 11'h7ff);
    end
    if (status_refresh === 1'b1) n_ref++;
    if (rd_done === 1'b1) begin
      n_rd++;
      chk("read target", {8'h0, rd_target},
        (tq.size() > 0) ? {8'h0, tq.pop_front()} : 11'h7ff);
    end
  end
  // ==========================================
  // scenarios
  initial begin
    int i;
    int p;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    // every target in both directions, alternating back to back
    for (p = 0; p < 2; p++) begin
      tdi_byte <= 8'($random(seed));
      other_rd_byte <= 8'($random(seed));
      // status is refreshed, then read, before the next round of buffer accesses
      for (i = 0; i < 16; i++) begin
        send(i[0], i[3:1], (i[3:1] == 3'h7) ? 8'h04 : 8'($random(seed)));
      end
      repeat (40) @(posedge ref_clk);
    end
    $display("end of test targets");
    // empty input buffer holds only its own reads
    tdi_has_byte <= 1'b0;
    send(1'b1, ahb_pkg::SEL_CNT, 8'h00);
    repeat (40) @(posedge ref_clk);
    chk("other read", 11'(rq.size()), 11'h0);
    send(1'b1, ahb_pkg::SEL_TDI, 8'h00);
    repeat (40) @(posedge ref_clk);
    chk("held read", {10'h0, bus.ready_wait}, 11'h1);
    chk("held read", 11'(rq.size()), 11'h1);
    tdi_has_byte <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("held read", 11'(rq.size()), 11'h0);
    $display("end of test input buffer");
    // full output buffers hold the write off
    for (i = 0; i < 3; i++) begin
      tdo_room <= (i != 0);
      tms0_full <= (i == 1);
      tms1_full <= (i == 2);
      send(1'b0, (i == 0) ? ahb_pkg::SEL_TDO : 3'(i + 1), 8'($random(seed)));
      repeat (40) @(posedge ref_clk);
      chk("held write", {10'h0, bus.ready_wait}, 11'h1);
      chk("held write", 11'(wq.size()), 11'h1);
      tdo_room <= 1'b1;
      tms0_full <= 1'b0;
      tms1_full <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk("held write", 11'(wq.size()), 11'h0);
    end
    $display("end of test output buffers");
    // stalled drain fills the fifo until the bus is held
    wr_ready <= 1'b0;
    fork
      for (int j = 0; j < 7; j++) send(1'b0, ahb_pkg::SEL_MODE1, 8'($random(seed)));
    join_none
    repeat (200) @(posedge ref_clk);
    chk("fifo full", {9'h0, wr_valid, bus.ready_wait}, 11'h3);
    repeat (300) begin
      @(posedge ref_clk);
      wr_ready <= 1'($random(seed));
    end
    wr_ready <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk("fifo drain", 11'(wq.size()), 11'h0);
    chk("refresh", 11'(n_ref), 11'(x_ref));
    chk("read done", 11'(n_rd), 11'(x_rd));
    $display("end of test fifo");
    end_sim();
  end
endmodule
